// file: common/usb_irq_defines.vh
// Constants for the USB interrupt-enable and descriptor base register block
`ifndef USB_IRQ_DEFINES_VH
`define USB_IRQ_DEFINES_VH
// Register byte offsets
`define OFS_IRQ_ENABLE 4'h0
`define OFS_PAGE_MID 4'h4
`define OFS_PAGE_HIGH 4'h8
`define OFS_EVENT_STATUS 4'hc
`define OFS_MODE 4'h0
// Widths
`define REG_W 8
`define EVT_W 8
// Event bit positions in status and enable
`define BIT_STALL 7
`define BIT_ATTACH 6
`define BIT_RESUME 5
`define BIT_IDLE 4
`define BIT_TOKEN 3
`define BIT_FRAME 2
`define BIT_ERROR 1
`define BIT_RESET_DETACH 0
// Reset value of every register
`define REG_RESET 8'h00
// Table alignment: low nine base bits
`define ALIGN_BITS 9
`define ALIGN_ZERO 9'h000
`define BASE_MID_LSB 16
`define BASE_LOW_W 7
`endif

// file: hw/event_latch.v
// Sticky event status bits with write-one-to-clear
`timescale 1ns/10ps
`default_nettype none
`include "usb_irq_defines.vh"
module event_latch (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Event pulses
  input wire [`EVT_W-1:0] event_in,
  // Clear request
  input wire clear_stb,
  input wire [`EVT_W-1:0] clear_mask,
  // Held status
  output reg [`EVT_W-1:0] status_q
);
  // Set wins over a clear in the same cycle so no event is lost
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      status_q <= `REG_RESET;
    end else begin
      status_q <= (status_q & ~(clear_stb ? clear_mask : `REG_RESET)) | event_in;
    end
  end
endmodule
`default_nettype wire

// file: hw/irq_gate.v
// Combines status and enable bits into one interrupt request
`timescale 1ns/10ps
`default_nettype none
`include "usb_irq_defines.vh"
module irq_gate (
  // Flags and enables
  input wire [`EVT_W-1:0] flags,
  input wire [`EVT_W-1:0] enables,
  // Combined request
  output wire irq
);
  // Each flag passes only under its own enable bit
  assign irq = |(flags & enables);
endmodule
`default_nettype wire

// file: hw/usb_irq_enable_and_descriptor_base.v
// Register bank: USB interrupt enable, descriptor table page registers
`timescale 1ns/10ps
`default_nettype none
`include "usb_irq_defines.vh"
module usb_irq_enable_and_descriptor_base (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Link mode: high selects host operation
  input wire host_mode,
  // Event pulses from the link
  input wire stall_event,
  input wire attach_event,
  input wire resume_event,
  input wire bus_idle_event,
  input wire token_done_flag,
  input wire frame_start_flag,
  input wire link_error_event,
  input wire bus_reset_flag,
  input wire detach_flag,
  // Outputs to the link unit
  output wire combined_link_irq_flag,
  output wire [31:0] descriptor_base
);
  // Register state
  reg [`REG_W-1:0] usb_interrupt_enable_q; // Enable bits
  reg [`REG_W-1:0] usb_descriptor_table_page_mid_q; // Base bits 23:16
  reg [`REG_W-1:0] usb_descriptor_table_page_high_q; // Base bits 31:24
  wire [`EVT_W-1:0] status;
  wire [`EVT_W-1:0] events;
  wire req;
  wire wr_stb;
  wire clr_stb;
  wire req_irq; // Gated request, declared before the gate drives it

  // Zero-extend an 8-bit register onto the 32-bit bus
  function [31:0] widen;
    input [`REG_W-1:0] v;
    begin
      widen = {24'h000000, v};
    end
  endfunction

  // Bit 0 source depends on mode: detach in host, bus reset in device
  assign events = {stall_event, attach_event, resume_event, bus_idle_event,
                   token_done_flag, frame_start_flag, link_error_event,
                   host_mode ? detach_flag : bus_reset_flag};

  // A request is taken once; ack drops the cycle after
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_stb = req & wb_we_i & wb_sel_i[0];
  assign clr_stb = wr_stb & (wb_adr_i == `OFS_EVENT_STATUS);

  // Sticky status, write one to clear
  event_latch u_latch (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .event_in(events),
    .clear_stb(clr_stb),
    .clear_mask(wb_dat_i[`REG_W-1:0]),
    .status_q(status)
  );

  // Enabled flags form the single interrupt line
  irq_gate u_gate (
    .flags(status),
    .enables(usb_interrupt_enable_q),
    .irq(req_irq)
  );
  assign combined_link_irq_flag = req_irq;

  // Base address: pages high, low 16 bits forced zero
  assign descriptor_base = {usb_descriptor_table_page_high_q,
                            usb_descriptor_table_page_mid_q,
                            `BASE_LOW_W'h00, `ALIGN_ZERO};

  // Register writes; only low byte lane is implemented
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      usb_interrupt_enable_q <= `REG_RESET;
      usb_descriptor_table_page_mid_q <= `REG_RESET;
      usb_descriptor_table_page_high_q <= `REG_RESET;
    end else if (wr_stb) begin
      case (wb_adr_i)
        `OFS_IRQ_ENABLE: begin
          usb_interrupt_enable_q <= wb_dat_i[`REG_W-1:0];
        end
        `OFS_PAGE_MID: begin
          usb_descriptor_table_page_mid_q <= wb_dat_i[`REG_W-1:0];
        end
        `OFS_PAGE_HIGH: begin
          usb_descriptor_table_page_high_q <= wb_dat_i[`REG_W-1:0];
        end
        default: begin
          // Status clear handled in the latch; others ignored
        end
      endcase
    end
  end

  // Ack and read data, one cycle after the request
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (req & ~wb_we_i) begin
        case (wb_adr_i)
          `OFS_IRQ_ENABLE: wb_dat_o <= widen(usb_interrupt_enable_q);
          `OFS_PAGE_MID: wb_dat_o <= widen(usb_descriptor_table_page_mid_q);
          `OFS_PAGE_HIGH: wb_dat_o <= widen(usb_descriptor_table_page_high_q);
          `OFS_EVENT_STATUS: wb_dat_o <= widen(status);
          default: wb_dat_o <= 32'h00000000; // Unmapped reads zero
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/usb_irq_checker_assertions.sv
// Bus and output checks for the USB interrupt enable bank
`timescale 1ns/10ps
`default_nettype none
module usb_irq_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Link side
  input wire logic combined_link_irq_flag,
  input wire logic [31:0] descriptor_base
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Request taken at this edge; a write only counts with byte lane 0
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic wr = req && wb_we_i && wb_sel_i[0];
  chk_ack_follows: assert property (req |=> wb_ack_o) else $error("ack late");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  chk_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_mid_page: assert property (wr && wb_adr_i == 4'h4 |=>
    descriptor_base[23:16] == $past(wb_dat_i[7:0])) else $error("mid page");
  chk_high_page: assert property (wr && wb_adr_i == 4'h8 |=>
    descriptor_base[31:24] == $past(wb_dat_i[7:0])) else $error("high page");
  chk_base_align: assert property (descriptor_base[8:0] == 9'h000)
    else $error("base unaligned");
  chk_reset_clear: assert property ($rose(reset_n) |-> descriptor_base == 32'h0 &&
    !combined_link_irq_flag) else $error("not cleared");
  chk_mid_readback: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h4 |->
    wb_dat_o[7:0] == descriptor_base[23:16]) else $error("mid readback");
  cover property (wr && wb_adr_i == 4'h8);
  cover property ($rose(combined_link_irq_flag));
  cover property ($fell(combined_link_irq_flag));
endmodule
bind usb_irq_enable_and_descriptor_base usb_irq_checker chk_u (.ref_clk, .reset_n,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .combined_link_irq_flag, .descriptor_base);
`default_nettype wire

// file: sim/usb_irq_enable_and_descriptor_base_test.sv
// Self-checking bench for the USB interrupt enable bank
`timescale 1ns/10ps
`default_nettype none
module usb_irq_enable_and_descriptor_base_test;
  logic ref_clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, host = 0;
  logic [3:0] adr = 0, sel = 0;
  logic [31:0] dat = 0, rd, q, base;
  logic ack, irq;
  logic [8:0] ev = 0; // Event pulses; bit 8 is detach
  integer fails = 0, cmp_count = 0, ticks = 0;
  usb_irq_enable_and_descriptor_base dut_u (.ref_clk, .reset_n, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(q), .wb_ack_o(ack), .host_mode(host), .stall_event(ev[7]),
    .attach_event(ev[6]), .resume_event(ev[5]), .bus_idle_event(ev[4]),
    .token_done_flag(ev[3]), .frame_start_flag(ev[2]), .link_error_event(ev[1]),
    .bus_reset_flag(ev[0]), .detach_flag(ev[8]), .combined_link_irq_flag(irq),
    .descriptor_base(base));
  initial forever #25 ref_clk = ~ref_clk;
  // Hang guard
  always @(posedge ref_clk) begin
    ticks <= ticks + 1;
    if (ticks == 3000) begin
      fails++;
      report_and_stop;
    end
  end
  task report_and_stop;
    $display("fails=%0d compares=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One classic cycle; answer taken at the edge where ack is seen
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    integer n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n == 20) fails++;
    rd = q;
    cyc <= 0;
    stb <= 0;
  endtask
  // Reset values, read/write, lane gating, unmapped place
  task regs_test;
    for (int a = 0; a < 12; a += 4) begin
      bus(0, a[3:0], 0, 4'hf);
      chk(rd, 0);
    end
    bus(1, 4'h4, 32'hffff_ff3c, 4'hf);
    bus(1, 4'h8, 32'hffff_ffc3, 4'hf);
    bus(1, 4'h4, 32'h0, 4'he);
    bus(0, 4'h8, 0, 4'hf);
    chk(rd, 32'hc3);
    chk(base, 32'hc33c_0000);
    bus(1, 4'h2, 32'hff, 4'hf);
    bus(0, 4'h2, 0, 4'hf);
    chk(rd, 0);
  endtask
  // Each source: masked, then unmasked, then cleared
  task irq_test;
    logic [7:0] m;
    for (int i = 0; i < 9; i++) begin
      m = (i == 8) ? 8'h01 : 8'h01 << i;
      bus(1, 4'h0, {24'h0, ~m}, 4'hf);
      host <= (i == 8);
      ev <= 9'h001 << i;
      @(posedge ref_clk);
      ev <= 0;
      @(posedge ref_clk);
      chk(irq, 0);
      bus(0, 4'hc, 0, 4'hf);
      chk(rd, {24'h0, m});
      bus(1, 4'h0, {24'h0, m}, 4'hf);
      @(posedge ref_clk);
      chk(irq, 1);
      bus(1, 4'hc, {24'h0, m}, 4'hf);
      @(posedge ref_clk);
      chk(irq, 0);
    end
    // Host mode: a bus-reset pulse must not reach bit 0
    ev <= 9'h001;
    @(posedge ref_clk);
    ev <= 0;
    @(posedge ref_clk);
    bus(0, 4'hc, 0, 4'hf);
    chk(rd, 0);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1;
    regs_test;
    irq_test;
    report_and_stop;
  end
endmodule
`default_nettype wire
